// ==== include/spi_port_pkg.sv ====
/*
  constants shared by both ends of the serial port link: register offsets,
  field positions, reset values, timing counts and engine states.
  assumes a single clock domain and a 32-bit classic wishbone register bus.
*/
package spi_port_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  // ----------------------------------------------------------------
  // serial_control_reg fields
  // ----------------------------------------------------------------
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_CPHA = 3;
  localparam int CTRL_CPOL = 4;
  localparam int CTRL_MASTER = 5;
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_IRQ_EN = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ----------------------------------------------------------------
  // serial_ctrl_status_reg fields
  // ----------------------------------------------------------------
  localparam int STAT_SOFT_LEVEL = 0;
  localparam int STAT_SOFT_EN = 1;
  localparam int STAT_MODE_FAULT_FLAG = 3;
  localparam int STAT_OVR = 4;
  localparam int STAT_WRITE_COLLISION_FLAG = 5;
  localparam int STAT_BUSY = 6;
  localparam int STAT_DONE = 7;
  localparam logic [1:0] SOFT_RST = 2'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0] RATE_MAX = 3'h5;     // six rates, cpu/4 .. cpu/128
  localparam logic [6:0] HALF_BASE = 7'h02;   // half period at cpu/4
  localparam logic [3:0] LAST_EDGE = 4'hF;    // sixteen edges per byte
  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} eng_state_e;
endpackage

// ==== include/spi_link_if.sv ====
/*
  the serial link between the port and its far party.
  resolves sck, mosi and miso from the drivers' enables; undriven lines read the pull.
  assumes SINGLE_LINE=1 when both data lines are tied together at every node.
*/
`timescale 1ns/1ps
interface spi_link_if #(
  parameter logic SCK_PULL = 1'b0,
  parameter logic SINGLE_LINE = 1'b0
);
  logic dev_sck_o, dev_sck_oe, ptn_sck_o, ptn_sck_oe;
  logic dev_mosi_o, dev_mosi_oe, ptn_mosi_o, ptn_mosi_oe;
  logic dev_miso_o, dev_miso_oe, ptn_miso_o, ptn_miso_oe;
  logic ptn_sel_n;
  logic sck, mosi, miso, sel_n, mosi_w, miso_w;

  // line resolution
  assign sck = dev_sck_oe ? dev_sck_o : (ptn_sck_oe ? ptn_sck_o : SCK_PULL);
  assign mosi_w = dev_mosi_oe ? dev_mosi_o : (ptn_mosi_oe ? ptn_mosi_o : 1'b1);
  assign miso_w = dev_miso_oe ? dev_miso_o : (ptn_miso_oe ? ptn_miso_o : 1'b1);
  assign mosi = SINGLE_LINE ? (mosi_w & miso_w) : mosi_w;   // see [R4]
  assign miso = SINGLE_LINE ? (mosi_w & miso_w) : miso_w;   // see [R4]
  assign sel_n = ptn_sel_n;

  modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
               input sck, mosi, miso, sel_n);
  modport ptn (output ptn_sck_o, ptn_sck_oe, ptn_mosi_o, ptn_mosi_oe, ptn_miso_o, ptn_miso_oe,
               ptn_sel_n, input sck, mosi, miso);
endinterface

// ==== core/spi_far_end.sv ====
/*
  far party of the link: a serial master or slave device with a plain user port.
  assumes the port at the other end is configured with the same cpol/cpha.
*/
`timescale 1ns/1ps
module spi_far_end
  import spi_port_pkg::*;
#(
  parameter logic [6:0] HALF = 7'h04  // mclk cycles per sck half period, at least 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user side
  input wire logic role_master,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx_byte,
  input wire logic start,
  output logic busy,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  // link
  spi_link_if.ptn link
);
  eng_state_e state_r;
  logic [7:0] tx_r, rx_r;
  logic [3:0] cnt_r;
  logic [6:0] div_r;
  logic sck_r, sck_prev_r, edge_evt, sample, change, din;
  logic [7:0] rx_nxt;

  // edge source: own divider as master, line edges as slave
  assign edge_evt = (state_r == ST_RUN) &&
                    (role_master ? (div_r == HALF - 7'd1) : (link.sck != sck_prev_r));
  assign sample = cpha ? cnt_r[0] : ~cnt_r[0];                 // see [R22]
  assign change = ~sample & ~(cpha & (cnt_r == 4'h0));
  assign din = role_master ? link.miso : link.mosi;           // see [R3]
  assign rx_nxt = {rx_r[6:0], din};                           // see [R2]

  // engine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      cnt_r <= 4'h0;
      div_r <= 7'h00;
      sck_r <= 1'b0;
      sck_prev_r <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      sck_prev_r <= link.sck;
      rx_valid <= 1'b0;
      if (state_r == ST_IDLE) begin
        sck_r <= cpol;
        div_r <= 7'h00;
        cnt_r <= 4'h0;
        if (start) begin
          tx_r <= tx_byte;
          state_r <= ST_RUN;
        end
      end else begin
        div_r <= (edge_evt || !role_master) ? 7'h00 : div_r + 7'd1;
        if (edge_evt) begin
          sck_r <= ~sck_r;
          cnt_r <= cnt_r + 4'd1;
          if (sample) begin
            rx_r <= rx_nxt;
          end
          if (change) begin
            tx_r <= {tx_r[6:0], 1'b0};
          end
          if (cnt_r == LAST_EDGE) begin
            rx_byte <= sample ? rx_nxt : rx_r;
            rx_valid <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
      end
    end
  end

  // pin drivers; select low only during a byte as master
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.ptn_sck_o <= 1'b0;
      link.ptn_sck_oe <= 1'b0;
      link.ptn_mosi_o <= 1'b1;
      link.ptn_mosi_oe <= 1'b0;
      link.ptn_miso_o <= 1'b1;
      link.ptn_miso_oe <= 1'b0;
      link.ptn_sel_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      link.ptn_sck_o <= (state_r == ST_RUN) ? (edge_evt ? ~sck_r : sck_r) : cpol;
      link.ptn_sck_oe <= role_master;
      link.ptn_mosi_o <= (state_r == ST_IDLE && start) ? tx_byte[7] :
                         (edge_evt && change) ? tx_r[6] : tx_r[7];  // next bit with the shift, ready at cpu/4
      link.ptn_mosi_oe <= role_master;
      link.ptn_miso_o <= (state_r == ST_IDLE && start) ? tx_byte[7] :
                         (edge_evt && change) ? tx_r[6] : tx_r[7];
      link.ptn_miso_oe <= ~role_master && (state_r == ST_RUN);
      link.ptn_sel_n <= ~(role_master && (state_r == ST_RUN)); // see [R9] [R18]
      busy <= (state_r == ST_RUN);
    end
  end
endmodule

// ==== core/spi_port.sv ====
/*
  serial port device end: byte shift engine with master clock divider, slave
  mode, completion and error flags, registers over a classic wishbone slave.
  assumes sck, mosi, miso and sel_n are synchronous to mclk and, as slave,
  sck runs no faster than mclk/2.
*/
// Chosen here: the address map and the Wishbone interface to the registers.
// Contract
// [R1] single master only; no multi-master arbitration
// [R2] bytes shift most significant bit first
// [R3] master starts; slave shifts on master clock
// [R4] single line: data lines tied, simplex only
// [R5] both ends share polarity and phase
// [R6] soft select replaces pin when enabled
// [R7] master keeps internal select high
// [R8] phase 1 slave keeps select low
// [R9] phase 0 slave select toggles per byte
// [R10] master clock: six rates, fastest cpu/4
// [R11] external master clocks at most cpu/2
// [R12] software configures master mode in order
// [R13] master and enable hold only while select high
// [R14] master data write loads shifter, starts
// [R15] completion sets flag, interrupt if enabled
// [R16] flag clears: status access then data read
// [R17] data writes ignored until status read
// [R18] master drives each slave select
// [R19] select low as master: fault, drop mode
// [R20] byte before flag clear: overrun, keep first
// [R21] write during transfer: collision flag only
// [R22] polarity sets idle; phase picks sample edge
`timescale 1ns/1ps
module spi_port
  import spi_port_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [3:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] dat_w,
  output logic [31:0] dat_r,
  output logic ack,
  // cpu interrupt mask and request
  input wire logic cpu_mask,
  output logic irq,
  // link
  spi_link_if.dev link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eng_state_e state_r;
  logic [7:0] ctrl_r, tx_r, rx_r, rx_buf_r;
  logic [1:0] soft_r;
  logic done_r, ovr_r, write_collision_flag_r, mode_fault_flag_r, stat_seen_r, mode_fault_flag_arm_r;
  logic [3:0] cnt_r;
  logic [5:0] div_r;
  logic sck_r, sck_prev_r;
  logic access, rd_ctrl, wr_ctrl, rd_stat, wr_stat, rd_data, wr_data;
  logic master, enable, cpha, ss_int, sel_act, mfault, comp, edge_evt, tick;
  logic sample, change, din, clr_flags, allow_set, wr_ok, collide;
  logic [2:0] rate;
  logic [6:0] half;
  logic [7:0] rx_nxt, stat_view;

  // ----------------------------------------------------------------
  // bus decode: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  assign access = cyc && stb && !ack;
  assign rd_ctrl = access && !we && (adr == OFF_CTRL);
  assign wr_ctrl = access && we && sel[0] && (adr == OFF_CTRL);
  assign rd_stat = access && !we && (adr == OFF_STAT);
  assign wr_stat = access && we && sel[0] && (adr == OFF_STAT);
  assign rd_data = access && !we && (adr == OFF_DATA);
  assign wr_data = access && we && sel[0] && (adr == OFF_DATA);

  // ----------------------------------------------------------------
  // mode and select
  // ----------------------------------------------------------------
  assign master = ctrl_r[CTRL_MASTER];
  assign enable = ctrl_r[CTRL_ENABLE];
  assign cpha = ctrl_r[CTRL_CPHA];
  assign ss_int = soft_r[STAT_SOFT_EN] ? soft_r[STAT_SOFT_LEVEL] : link.sel_n; // see [R6]
  assign sel_act = enable && !master && !ss_int;
  assign mfault = enable && master && !ss_int;                              // see [R19] [R1]
  assign allow_set = ss_int && (!mode_fault_flag_r || mode_fault_flag_arm_r);                     // see [R13]

  // master rate: half period 2,4,..,64 cycles
  assign rate = (ctrl_r[CTRL_RATE_LSB +: 3] > RATE_MAX) ? RATE_MAX : ctrl_r[CTRL_RATE_LSB +: 3];
  assign half = HALF_BASE << rate;                                          // see [R10]
  assign tick = ({1'b0, div_r} == half - 7'd1);

  // edge source and per-edge actions
  assign edge_evt = master ? ((state_r == ST_RUN) && tick)
                           : (sel_act && (link.sck != sck_prev_r));         // see [R3] [R11]
  assign sample = cpha ? cnt_r[0] : ~cnt_r[0];                              // see [R22] [R5]
  assign change = ~sample & ~(cpha & (cnt_r == 4'h0));
  assign din = master ? link.miso : link.mosi;
  assign rx_nxt = {rx_r[6:0], din};                                         // see [R2]
  assign comp = edge_evt && (cnt_r == LAST_EDGE);

  // data write screening
  assign wr_ok = !(done_r && !stat_seen_r);                                 // see [R17]
  assign collide = (state_r == ST_RUN) || (sel_act && !cpha);               // see [R21] [R9]
  assign clr_flags = stat_seen_r && (rd_data || (wr_data && !master));      // see [R16]

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || !enable) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      div_r <= 6'h00;
      sck_r <= 1'b0;
      rx_r <= 8'h00;
    end else begin
      div_r <= (state_r == ST_RUN && master && !tick) ? div_r + 6'd1 : 6'h00;
      if (state_r == ST_IDLE) begin
        sck_r <= ctrl_r[CTRL_CPOL];                                         // see [R22]
        if (wr_data && wr_ok && !collide && master) begin
          state_r <= ST_RUN;                                                // see [R14]
        end
      end
      if (!master && !sel_act) begin
        state_r <= ST_IDLE;                                                 // deselect aborts a slave byte
        cnt_r <= 4'h0;
      end else if (edge_evt) begin
        sck_r <= ~sck_r;
        cnt_r <= cnt_r + 4'd1;
        state_r <= comp ? ST_IDLE : ST_RUN;
        if (sample) begin
          rx_r <= rx_nxt;
        end
      end
    end
  end

  // transmit shifter: loaded by accepted writes, moved on change edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_r <= 8'h00;
    end else if (wr_data && wr_ok && !collide) begin
      tx_r <= dat_w[7:0];                                                   // see [R14]
    end else if (edge_evt && change) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // previous line clock for slave edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= link.sck;
    end
  end

  // ----------------------------------------------------------------
  // control and select registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      soft_r <= SOFT_RST;
    end else begin
      if (wr_stat) begin
        soft_r <= dat_w[1:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= {dat_w[7], dat_w[6:5] & {2{allow_set}}, dat_w[4:0]};      // see [R12] [R13]
      end
      if (mfault) begin
        ctrl_r[CTRL_MASTER] <= 1'b0;                                        // see [R19]
        ctrl_r[CTRL_ENABLE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_r <= 1'b0;
      ovr_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      stat_seen_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
      rx_buf_r <= 8'h00;
    end else begin
      if (comp) begin
        done_r <= 1'b1;                                                     // see [R15]
      end else if (clr_flags) begin
        done_r <= 1'b0;                                                     // see [R16]
      end
      if (comp && done_r) begin
        ovr_r <= 1'b1;                                                      // see [R20]
      end else if (rd_stat) begin
        ovr_r <= 1'b0;
      end
      if (comp && !done_r) begin
        rx_buf_r <= sample ? rx_nxt : rx_r;                                 // see [R20]
      end
      if (wr_data && wr_ok && collide) begin
        write_collision_flag_r <= 1'b1;                                                     // see [R21] [R9]
      end else if (clr_flags) begin
        write_collision_flag_r <= 1'b0;
      end
      if (rd_stat && (done_r || write_collision_flag_r)) begin
        stat_seen_r <= 1'b1;
      end else if (rd_data || wr_data) begin
        stat_seen_r <= 1'b0;
      end
      if (mfault) begin
        mode_fault_flag_r <= 1'b1;                                                     // see [R19]
      end else if (wr_ctrl && mode_fault_flag_arm_r) begin
        mode_fault_flag_r <= 1'b0;
      end
      if (rd_stat && mode_fault_flag_r) begin
        mode_fault_flag_arm_r <= 1'b1;
      end else if (wr_ctrl) begin
        mode_fault_flag_arm_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus answer, interrupt and pin drivers
  // ----------------------------------------------------------------
  assign stat_view = {done_r, state_r == ST_RUN, write_collision_flag_r, ovr_r, mode_fault_flag_r, 1'b0, soft_r};

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
      dat_r <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      ack <= access;
      dat_r <= rd_ctrl ? {24'h000000, ctrl_r} :
               rd_stat ? {24'h000000, stat_view} :
               rd_data ? {24'h000000, rx_buf_r} : 32'h0000_0000;
      irq <= ctrl_r[CTRL_IRQ_EN] && !cpu_mask && (done_r || mode_fault_flag_r || ovr_r); // see [R15] [R19] [R20]
    end
  end

  // outputs blocked unless enabled; master drives clock and mosi
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.dev_sck_o <= 1'b0;
      link.dev_sck_oe <= 1'b0;
      link.dev_mosi_o <= 1'b1;
      link.dev_mosi_oe <= 1'b0;
      link.dev_miso_o <= 1'b1;
      link.dev_miso_oe <= 1'b0;
    end else begin
      link.dev_sck_o <= (state_r == ST_RUN && edge_evt) ? ~sck_r :
                        (state_r == ST_RUN) ? sck_r : ctrl_r[CTRL_CPOL];
      link.dev_sck_oe <= enable && master && !mfault;
      link.dev_mosi_o <= (wr_data && wr_ok && !collide) ? dat_w[7] :
                         (edge_evt && change) ? tx_r[6] : tx_r[7];
      link.dev_mosi_oe <= enable && master && !mfault;
      link.dev_miso_o <= (wr_data && wr_ok && !collide) ? dat_w[7] :
                         (edge_evt && change) ? tx_r[6] : tx_r[7];
      link.dev_miso_oe <= sel_act;
    end
  end
endmodule

// ==== testbench/spi_port_asserts.sv ====
/*
  concurrent checks on the serial link between the port and its far end.
  assumes one clock domain and is instantiated beside the link interface.
*/
`timescale 1ns/1ps
module spi_port_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // resolved lines
  input wire logic sck,
  input wire logic sel_n,
  // drivers
  input wire logic ptn_sel_n,
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic ptn_sck_oe,
  input wire logic ptn_mosi_oe,
  input wire logic ptn_miso_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  // port lines released when reset ends
  reset_release_a: assert property (
    $fell(rst) |-> !dev_sck_oe && !dev_mosi_oe && !dev_miso_oe) else $error("port drives link after reset");
  // select pulled low under a master port drops the clock driver
  mode_fault_a: assert property (
    !sel_n && dev_sck_oe |-> ##[1:3] !dev_sck_oe) else $error("clock kept after mode fault");
  // port clock levels last two cycles at least
  sck_half_a: assert property (
    dev_sck_oe && $past(dev_sck_oe) && $changed(sck) |=> $stable(sck)) else $error("port sck too fast");
  // far master clock levels last two cycles at least
  far_half_a: assert property (
    ptn_sck_oe && $past(ptn_sck_oe) && $changed(sck) |=> $stable(sck)) else $error("far sck too fast");
  // port only clocks while its select is high
  master_sel_a: assert property (
    dev_sck_oe && $past(dev_sck_oe) && $changed(sck) |-> sel_n) else $error("port clocks while selected");
  // far master selects the slave through the byte
  far_sel_a: assert property (
    ptn_sck_oe && $past(ptn_sck_oe) && $changed(sck) |-> !ptn_sel_n) else $error("far clocks unselected");
  // slave out excludes master lines on the port
  dev_dir_a: assert property (
    dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe) else $error("port drives both directions");
  // slave out excludes master lines on the far end
  far_dir_a: assert property (
    ptn_miso_oe |-> !ptn_sck_oe && !ptn_mosi_oe) else $error("far end drives both directions");
endmodule

// ==== testbench/spi_master_slave_port_tb_top.sv ====
/*
  self-checking bench: port and far end joined by the link interface.
  assumes the register map and timing of spi_port_pkg and far end HALF 4.
*/
`timescale 1ns/1ps
module spi_master_slave_port_tb_top
  import spi_port_pkg::*;
;
  logic mclk, rst, cyc, stb, we, ack, cpu_mask, irq;
  logic [3:0] adr, sel;
  logic [31:0] dat_w, dat_r;
  logic role_master, cpol, cpha, start, busy, rx_valid, sck_q;
  logic [7:0] tx_byte, rx_byte, far_rx;
  int n_mismatch, n_compared, n_far, edge_n, gap, last_gap;
  logic [2:0] rates [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
  // ----------------------------------------------------------------
  // link, both ends, checker
  // ----------------------------------------------------------------
  spi_link_if link ();
  spi_port spi_port_i (.mclk(mclk), .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .cpu_mask(cpu_mask), .irq(irq), .link(link));
  spi_far_end spi_far_end_i (.mclk(mclk), .rst(rst), .role_master(role_master), .cpol(cpol), .cpha(cpha),
    .tx_byte(tx_byte), .start(start), .busy(busy), .rx_byte(rx_byte), .rx_valid(rx_valid), .link(link));
  spi_port_asserts spi_port_asserts_i (.mclk(mclk), .rst(rst), .sck(link.sck), .sel_n(link.sel_n),
    .ptn_sel_n(link.ptn_sel_n), .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .ptn_sck_oe(link.ptn_sck_oe), .ptn_mosi_oe(link.ptn_mosi_oe),
    .ptn_miso_oe(link.ptn_miso_oe));
  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // sck edge count and spacing, far end receive capture
  always @(posedge mclk) begin
    sck_q <= link.sck;
    gap <= (link.sck !== sck_q) ? 1 : gap + 1;
    if (link.sck !== sck_q) begin
      edge_n <= edge_n + 1;
      last_gap <= gap;
    end
    if (rx_valid === 1'b1) begin
      n_far <= n_far + 1;
      far_rx <= rx_byte;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(name, exp, q);
  endtask
  // waits for the far end to count n bytes received
  task automatic wait_far(input int n);
    for (int k = 0; k < 4000 && n_far < n; k++) @(posedge mclk);
    if (n_far < n) begin
      n_mismatch++;
      close_out();
    end
    repeat (4) @(posedge mclk);
  endtask
  task automatic far_go(input logic m, input logic [7:0] d);
    @(posedge mclk);
    role_master <= m;
    tx_byte <= d;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    rd_chk("ctrl", OFF_CTRL, CTRL_RST);
    rd_chk("status", OFF_STAT, 8'h00);
    rd_chk("unmapped", 4'hC, 8'h00);
  endtask
  // port as master in all four modes, rates incl. the clamp
  task automatic master_bytes();
    logic [7:0] ctl, a, b;
    logic [2:0] rr;
    int e0, n0;
    for (int m = 0; m < 4; m++) begin
      rr = (rates[m] > RATE_MAX) ? RATE_MAX : rates[m];
      ctl = {3'h0, m[1], m[0], rates[m]};
      a = 8'h35 + {m[1:0], 6'h00};
      b = 8'hCA - 8'(m);
      cpol <= m[1];
      cpha <= m[0];
      cpu_mask <= m[0];
      wr(OFF_CTRL, ctl);
      wr(OFF_STAT, 8'h03);
      wr(OFF_CTRL, ctl | 8'hE0);
      far_go(1'b0, b);
      chk("sck idle", {7'h00, m[1]}, {7'h00, link.sck});
      e0 = edge_n;
      n0 = n_far;
      wr(OFF_DATA, a);
      if (m == 2) wr(OFF_DATA, 8'h00);
      wait_far(n0 + 1);
      if (m == 3) wr(OFF_DATA, 8'h00);
      repeat (20) @(posedge mclk);
      chk("far rx", a, far_rx);
      chk("edges", 8'h10, 8'(edge_n - e0));
      chk("half", 8'h02 << rr, 8'(last_gap));
      chk("irq", {7'h00, ~m[0]}, {7'h00, irq});
      rd_chk("rx early", OFF_DATA, b);
      rd_chk("status", OFF_STAT, (m == 2) ? 8'hA3 : 8'h83);
      rd_chk("rx", OFF_DATA, b);
      rd_chk("cleared", OFF_STAT, 8'h03);
    end
  endtask
  // port as phase 1 slave, two bytes without a flag clear
  task automatic slave_overrun();
    int n0;
    cpol <= 1'b0;
    cpha <= 1'b1;
    wr(OFF_CTRL, 8'h48);
    wr(OFF_STAT, 8'h02);
    wr(OFF_DATA, 8'h3C);
    n0 = n_far;
    far_go(1'b1, 8'h5A);
    wait_far(n0 + 1);
    chk("slave out", 8'h3C, far_rx);
    far_go(1'b1, 8'hE1);
    wait_far(n0 + 2);
    rd_chk("overrun", OFF_STAT, 8'h92);
    rd_chk("kept", OFF_DATA, 8'h5A);
    rd_chk("ovr clr", OFF_STAT, 8'h02);
  endtask
  // far master selects the port while it is master
  task automatic mode_fault();
    int n0;
    cpha <= 1'b0;
    cpu_mask <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_STAT, 8'h00);
    wr(OFF_CTRL, 8'hE0);
    rd_chk("master on", OFF_CTRL, 8'hE0);
    n0 = n_far;
    far_go(1'b1, 8'h77);
    repeat (4) @(posedge mclk);
    chk("fault irq", 8'h01, {7'h00, irq});
    chk("far busy", 8'h01, {7'h00, busy});
    rd_chk("fault", OFF_STAT, 8'h08);
    wr(OFF_CTRL, 8'hE0);
    rd_chk("dropped", OFF_CTRL, 8'h80);
    wait_far(n0 + 1);
    chk("far idle", 8'h00, {7'h00, busy});
    rd_chk("fault clr", OFF_STAT, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hF;
    dat_w = 32'h00000000;
    cpu_mask = 1'b0;
    role_master = 1'b0;
    cpol = 1'b0;
    cpha = 1'b0;
    start = 1'b0;
    tx_byte = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    n_far = 0;
    edge_n = 0;
    gap = 0;
    last_gap = 0;
    sck_q = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    reset_values();
    master_bytes();
    slave_overrun();
    mode_fault();
    close_out();
  end
endmodule
